// ===== core/lcd_host_pkg.sv
// constants and types shared by the dot matrix display controller
package lcd_host_pkg;

    // ----------------------------------------------------------------
    // register selection codes on the three index bits
    // ----------------------------------------------------------------
    localparam logic [2:0] IDX_DUTY = 3'h0;
    localparam logic [2:0] IDX_DISPLAY_ON_BIT = 3'h1;
    localparam logic [2:0] IDX_ADDR = 3'h2;
    localparam logic [2:0] IDX_FRAME = 3'h3;
    localparam logic [2:0] IDX_DATA = 3'h4;
    localparam logic [2:0] IDX_RESET = 3'h0;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned STBY_BIT = 5;
    localparam int unsigned DUTY8_BIT = 1;
    localparam int unsigned DISPLAY_ON_BIT_BIT = 6;
    localparam int unsigned INTERNAL_SUPPLY_SELECT_BIT = 5;
    localparam int unsigned BLEEDER_USE_SELECT_BIT = 4;
    localparam int unsigned RMW_BIT = 3;
    localparam int unsigned INC_BIT = 1;
    localparam int unsigned XA_LSB = 5;
    localparam int unsigned YA_LSB = 0;
    localparam int unsigned FS_LSB = 0;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [2:0] XA_RESET = 3'h0;
    localparam logic [3:0] YA_RESET = 4'h0;
    localparam logic [2:0] FS_RESET = 3'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // display memory geometry
    // ----------------------------------------------------------------
    localparam int unsigned COLS = 5;
    localparam int unsigned ROWS = 16;
    localparam int unsigned SEGS = 40;
    localparam int unsigned MEM_DEPTH = 80;
    localparam int unsigned MEM_AW = 7;
    localparam logic [2:0] X_LAST = 3'h4;
    localparam logic [3:0] Y_LAST16 = 4'hF;
    localparam logic [3:0] Y_LAST8 = 4'h7;

    // ----------------------------------------------------------------
    // frame timing: subclock ticks per common line = base << code
    // ----------------------------------------------------------------
    localparam logic [10:0] RATIO_BASE = 11'h008;
    localparam logic [10:0] TICK_ONE = 11'h001;

    typedef enum logic [2:0] {
        SC_IDLE = 3'b001,
        SC_FETCH = 3'b010,
        SC_LOAD = 3'b100
    } scan_state_t;

endpackage

// ===== core/lcd_dot_memory.sv
// bit-mapped display memory, one write port and two registered read ports
`timescale 1ns/1ps
module lcd_dot_memory
    import lcd_host_pkg::*;
(
    input wire logic sys_clk_i, // system clock
    input wire logic we_i, // write enable
    input wire logic [MEM_AW-1:0] waddr_i, // write byte address
    input wire logic [7:0] wdata_i, // write data
    input wire logic [MEM_AW-1:0] raddr_a_i, // host read address
    output logic [7:0] rdata_a_o, // host read data, registered
    input wire logic [MEM_AW-1:0] raddr_b_i, // scan read address
    output logic [7:0] rdata_b_o // scan read data, registered
);

    // 80 bytes of 8 dots each, 640 dots in all
    logic [7:0] mem [MEM_DEPTH];

    always_ff @(posedge sys_clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_a_o <= mem[raddr_a_i];
        rdata_b_o <= mem[raddr_b_i];
    end

endmodule // lcd_dot_memory

// ===== core/lcd_host_port.sv
// host port, control registers, address counter and panel scan
`timescale 1ns/1ps
// Overview of operation
// - hold 640 bits of dot memory
// - memory as 40x16 or 40x8 bits
// - select 1/8 or 1/16 duty drive
// - scan timing runs from the subclock
// - data read/write, display on/off, read-modify-write
// - drive 16 commons and 40 segments
// - one index plus five control registers via port
// - only display data register is readable
// - write with select low loads index
// - select high: index picks target register
// - data register read and written when selected
// - other index codes invalid; index resets zero
// - standby clears display and supply bits
// - address increments on access, writes only in mode
// - field wraps then carries into other field
module lcd_host_port
    import lcd_host_pkg::*;
(
    input wire logic sys_clk_i, // 50 MHz system clock
    input wire logic sys_rst_i, // synchronous reset, active high
    input wire logic subclk_i, // low-frequency subclock, synchronous level
    input wire logic register_select_line_i, // low: index, high: selected register
    input wire logic wr_i, // host write strobe, one cycle
    input wire logic rd_i, // host read strobe, one cycle
    input wire logic [7:0] data_i, // port data from host
    output logic [7:0] data_o, // port data to host
    output logic data_oe_o, // high while the block drives the port
    output logic [15:0] common_outputs_o, // common lines, one-hot active row
    output logic [39:0] segment_outputs_o, // segment lines of the active row
    output logic standby_o, // module standby
    output logic internal_supply_o, // internal supply to the bleeder
    output logic bleeder_use_o // built-in bleeder resistances used
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [2:0] register_index_q, register_index_d;
    logic module_standby_bit_q, module_standby_bit_d;
    logic duty8_q, duty8_d;
    logic display_on_bit_q, display_on_bit_d;
    logic internal_supply_select_q, internal_supply_select_d;
    logic bleeder_use_select_q, bleeder_use_select_d;
    logic write_only_increment_mode_q, write_only_increment_mode_d;
    logic x_priority_q, x_priority_d;
    logic [2:0] xa_q, xa_d;
    logic [3:0] ya_q, ya_d;
    logic [2:0] fs_q, fs_d;
    logic rd_pend_q, rd_pend_d, data_oe_q, data_oe_d;
    logic [7:0] data_q, data_d;

    logic wr_index, wr_sel, rd_data, wr_data, bump;
    logic [3:0] y_last;
    logic [MEM_AW-1:0] host_addr, scan_addr;
    logic [7:0] rdata_a, rdata_b;

    function automatic logic [MEM_AW-1:0] mem_index(input logic [2:0] x, input logic [3:0] y);
        mem_index = MEM_AW'({y, 2'b00}) + MEM_AW'(y) + MEM_AW'(x);
    endfunction

    assign wr_index = wr_i & ~register_select_line_i;
    assign wr_sel = wr_i & register_select_line_i;
    assign wr_data = wr_sel & (register_index_q == IDX_DATA);
    assign rd_data = rd_i & ~wr_i & register_select_line_i & (register_index_q == IDX_DATA);
    assign bump = wr_data | (rd_data & ~write_only_increment_mode_q);
    assign y_last = duty8_q ? Y_LAST8 : Y_LAST16;
    assign host_addr = mem_index(xa_q, ya_q);

    // ----------------------------------------------------------------
    // register writes and address counter
    // ----------------------------------------------------------------
    always_comb
    begin
        register_index_d = register_index_q;
        module_standby_bit_d = module_standby_bit_q;
        duty8_d = duty8_q;
        display_on_bit_d = display_on_bit_q;
        internal_supply_select_d = internal_supply_select_q;
        bleeder_use_select_d = bleeder_use_select_q;
        write_only_increment_mode_d = write_only_increment_mode_q;
        x_priority_d = x_priority_q;
        xa_d = xa_q;
        ya_d = ya_q;
        fs_d = fs_q;
        // upper five bits are reserved and never stored
        if (wr_index)
            register_index_d = data_i[2:0];
        if (wr_sel)
        begin
            case (register_index_q)
                IDX_DUTY:
                begin
                    module_standby_bit_d = data_i[STBY_BIT];
                    duty8_d = data_i[DUTY8_BIT];
                end
                IDX_DISPLAY_ON_BIT:
                begin
                    display_on_bit_d = data_i[DISPLAY_ON_BIT_BIT];
                    internal_supply_select_d = data_i[INTERNAL_SUPPLY_SELECT_BIT];
                    bleeder_use_select_d = data_i[BLEEDER_USE_SELECT_BIT];
                    write_only_increment_mode_d = data_i[RMW_BIT];
                    x_priority_d = data_i[INC_BIT];
                end
                IDX_ADDR:
                begin
                    xa_d = data_i[XA_LSB +: 3];
                    ya_d = data_i[YA_LSB +: 4];
                end
                IDX_FRAME:
                    fs_d = data_i[FS_LSB +: 3];
                default:
                    ; // data register handled below; other codes ignored
            endcase
        end
        // the selected field wraps after its last position and carries
        if (bump && x_priority_q)
        begin
            xa_d = (xa_q >= X_LAST) ? XA_RESET : xa_q + 3'h1;
            if (xa_q >= X_LAST)
                ya_d = (ya_q >= y_last) ? YA_RESET : ya_q + 4'h1;
        end
        if (bump && !x_priority_q)
        begin
            ya_d = (ya_q >= y_last) ? YA_RESET : ya_q + 4'h1;
            if (ya_q >= y_last)
                xa_d = (xa_q >= X_LAST) ? XA_RESET : xa_q + 3'h1;
        end
        // read path: bus driven for one cycle, two cycles after strobe
        rd_pend_d = rd_data;
        data_oe_d = rd_pend_q;
        data_d = rd_pend_q ? rdata_a : BYTE_RESET;
        // standby forces display and supply selects low and holds them there
        if (module_standby_bit_d)
        begin
            display_on_bit_d = 1'b0;
            internal_supply_select_d = 1'b0;
            bleeder_use_select_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            register_index_q <= IDX_RESET;
            module_standby_bit_q <= 1'b0;
            duty8_q <= 1'b0;
            display_on_bit_q <= 1'b0;
            internal_supply_select_q <= 1'b0;
            bleeder_use_select_q <= 1'b0;
            write_only_increment_mode_q <= 1'b0;
            x_priority_q <= 1'b0;
            xa_q <= XA_RESET;
            ya_q <= YA_RESET;
            fs_q <= FS_RESET;
            rd_pend_q <= 1'b0;
            data_oe_q <= 1'b0;
            data_q <= BYTE_RESET;
        end
        else
        begin
            register_index_q <= register_index_d;
            module_standby_bit_q <= module_standby_bit_d;
            duty8_q <= duty8_d;
            display_on_bit_q <= display_on_bit_d;
            internal_supply_select_q <= internal_supply_select_d;
            bleeder_use_select_q <= bleeder_use_select_d;
            write_only_increment_mode_q <= write_only_increment_mode_d;
            x_priority_q <= x_priority_d;
            xa_q <= xa_d;
            ya_q <= ya_d;
            fs_q <= fs_d;
            rd_pend_q <= rd_pend_d;
            data_oe_q <= data_oe_d;
            data_q <= data_d;
        end
    end

    lcd_dot_memory u_mem (
        .sys_clk_i(sys_clk_i),
        .we_i(wr_data),
        .waddr_i(host_addr),
        .wdata_i(data_i),
        .raddr_a_i(host_addr),
        .rdata_a_o(rdata_a),
        .raddr_b_i(scan_addr),
        .rdata_b_o(rdata_b)
    );

    // ----------------------------------------------------------------
    // panel scan on subclock ticks
    // ----------------------------------------------------------------
    scan_state_t scan_q, scan_d;
    logic sub_q, sub_d, sub_prev_q, sub_prev_d;
    logic [10:0] tick_cnt_q, tick_cnt_d;
    logic [3:0] row_q, row_d;
    logic [2:0] col_q, col_d, col_prev_q, col_prev_d;
    logic cap_q, cap_d, sub_tick, row_end;
    logic [39:0] seg_buf_q, seg_buf_d, seg_q, seg_d;
    logic [15:0] com_q, com_d;
    logic [10:0] row_len;

    // subclock is synchronous, so a plain edge detect serves
    assign sub_tick = sub_q & ~sub_prev_q;
    assign row_len = RATIO_BASE << fs_q;
    assign row_end = sub_tick & (tick_cnt_q >= row_len - TICK_ONE);
    assign scan_addr = mem_index(col_q, row_q);

    always_comb
    begin
        sub_d = subclk_i;
        sub_prev_d = sub_q;
        scan_d = scan_q;
        tick_cnt_d = tick_cnt_q;
        row_d = row_q;
        col_d = col_q;
        col_prev_d = col_q;
        cap_d = 1'b0;
        seg_buf_d = seg_buf_q;
        com_d = com_q;
        seg_d = seg_q;
        if (cap_q)
            seg_buf_d[8*col_prev_q +: 8] = rdata_b;
        if (sub_tick)
            tick_cnt_d = row_end ? 11'h000 : tick_cnt_q + TICK_ONE;
        case (scan_q)
            SC_IDLE:
            begin
                // standby halts the scan, saving subclock power
                if (row_end && !module_standby_bit_q)
                begin
                    row_d = (row_q >= y_last) ? YA_RESET : row_q + 4'h1;
                    col_d = XA_RESET;
                    scan_d = SC_FETCH;
                end
            end
            SC_FETCH:
            begin
                cap_d = 1'b1;
                if (col_q >= X_LAST)
                    scan_d = SC_LOAD;
                else
                    col_d = col_q + 3'h1;
            end
            SC_LOAD:
            begin
                seg_d = seg_buf_d;
                com_d = 16'h0001 << row_q;
                scan_d = SC_IDLE;
            end
            default:
                scan_d = SC_IDLE;
        endcase
        // display off pulls every line to the low level at once
        if (!display_on_bit_q)
        begin
            com_d = 16'h0000;
            seg_d = 40'h00_0000_0000;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            scan_q <= SC_IDLE;
            sub_q <= 1'b0;
            sub_prev_q <= 1'b0;
            tick_cnt_q <= 11'h000;
            row_q <= YA_RESET;
            col_q <= XA_RESET;
            col_prev_q <= XA_RESET;
            cap_q <= 1'b0;
            seg_buf_q <= 40'h00_0000_0000;
            com_q <= 16'h0000;
            seg_q <= 40'h00_0000_0000;
        end
        else
        begin
            scan_q <= scan_d;
            sub_q <= sub_d;
            sub_prev_q <= sub_prev_d;
            tick_cnt_q <= tick_cnt_d;
            row_q <= row_d;
            col_q <= col_d;
            col_prev_q <= col_prev_d;
            cap_q <= cap_d;
            seg_buf_q <= seg_buf_d;
            com_q <= com_d;
            seg_q <= seg_d;
        end
    end

    assign data_o = data_q;
    assign data_oe_o = data_oe_q;
    assign common_outputs_o = com_q;
    assign segment_outputs_o = seg_q;
    assign standby_o = module_standby_bit_q;
    assign internal_supply_o = internal_supply_select_q;
    assign bleeder_use_o = bleeder_use_select_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_index_load: assert property (wr_index |=> register_index_q == $past(data_i[2:0]))
        else $error("index not loaded");
    a_wo_no_drive: assert property (rd_i && !wr_i && register_select_line_i
        && register_index_q != IDX_DATA |=> ##1 !data_oe_o)
        else $error("write-only register drove the bus");
    a_data_read: assert property (rd_data ##1 !rd_data |=> data_oe_o ##1 !data_oe_o)
        else $error("read data not presented for one cycle");
    a_bus_quiet: assert property (data_oe_o |-> $past(rd_data, 2))
        else $error("bus driven outside a read");
    a_standby_clear: assert property (module_standby_bit_q |-> !display_on_bit_q
        && !internal_supply_select_q && !bleeder_use_select_q)
        else $error("standby left display or supply bits set");
    a_rmw_hold: assert property (rd_data && write_only_increment_mode_q
        |=> xa_q == $past(xa_q) && ya_q == $past(ya_q))
        else $error("address moved on a read-modify-write read");
    a_y_wrap: assert property (bump && !x_priority_q && ya_q == y_last && xa_q < X_LAST
        |=> ya_q == YA_RESET && xa_q == $past(xa_q) + 3'h1)
        else $error("y field did not wrap and carry");
    a_x_wrap: assert property (bump && x_priority_q && xa_q == X_LAST && ya_q < y_last
        |=> xa_q == XA_RESET && ya_q == $past(ya_q) + 4'h1)
        else $error("x field did not wrap and carry");
    a_invalid_index: assert property (wr_sel && register_index_q > IDX_DATA
        |=> $stable(fs_q) && $stable(xa_q) && $stable(duty8_q))
        else $error("invalid index changed a register");
    a_com_onehot: assert property ($onehot0(common_outputs_o)
        && !(duty8_q && $rose(|common_outputs_o[15:8])))
        else $error("common lines not one-hot within duty");
    a_row_on_tick: assert property (row_q != $past(row_q) |-> $past(row_end))
        else $error("row advanced without a subclock tick");
    a_display_off: assert property (!display_on_bit_q |=> common_outputs_o == 16'h0000
        && segment_outputs_o == 40'h00_0000_0000)
        else $error("outputs active while display off");

    c_read: cover property (rd_data ##2 data_oe_o);
    c_rmw_write: cover property (wr_data && write_only_increment_mode_q);
    c_row_shown: cover property (scan_q == SC_LOAD && display_on_bit_q);
    c_standby: cover property ($rose(module_standby_bit_q));

endmodule // lcd_host_port

// ===== tb/host_cpu_model.sv
// host cpu model driving the port lines of the display controller
`timescale 1ns/1ps
module host_cpu_model
    import lcd_host_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic [7:0] rdata_i, // port data from the block
    input wire logic oe_i, // block drives the port
    output logic sel_o, // register select line
    output logic wr_o, // write strobe
    output logic rd_o, // read strobe
    output logic [7:0] wdata_o // port data to the block
);
    initial
    begin
        sel_o = 1'b0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end

    // ------------------------------------------------------------
    // one write cycle; released data shows the inverse, not a hold
    // ------------------------------------------------------------
    task automatic put(input logic sel, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        sel_o = sel;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask

    // index upper bits always zero
    task automatic reg_wr(input logic [2:0] idx, input logic [7:0] v);
        put(1'b0, {5'h00, idx});
        put(1'b1, v);
    endtask

    task automatic get(output logic [7:0] d, output logic ok);
        int n;
        @(posedge clk_i);
        #1;
        sel_o = 1'b1;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        ok = 1'b0;
        d = 8'h00;
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (oe_i === 1'b1)
            begin
                ok = 1'b1;
                d = rdata_i;
            end
            else
            begin
                @(posedge clk_i);
                #1;
            end
        end
    endtask
endmodule // host_cpu_model

// ===== tb/tb_top.sv
// self-checking testbench of the display controller host port
`timescale 1ns/1ps
module tb_top;
    import lcd_host_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic subclk = 1'b0;
    logic sel, wr, rd, oe, stby, isup, bleed, ok;
    logic [7:0] wdata, rdata, d;
    logic [15:0] commons;
    logic [39:0] segs;
    logic [3:0] div = 4'h0;
    int mismatches = 0;
    int n_tests = 0;

    always #10 sys_clk = ~sys_clk;
    // subclock rises every 32 clocks, so a row of 8 ticks is 256 clocks
    always @(posedge sys_clk)
    begin
        div <= div + 4'h1;
        if (div == 4'h7)
            subclk <= ~subclk;
    end

    lcd_host_port u_lcd_host_port (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .subclk_i(subclk),
        .register_select_line_i(sel), .wr_i(wr), .rd_i(rd), .data_i(wdata),
        .data_o(rdata), .data_oe_o(oe), .common_outputs_o(commons),
        .segment_outputs_o(segs), .standby_o(stby), .internal_supply_o(isup),
        .bleeder_use_o(bleed)
    );
    host_cpu_model u_host_cpu_model (
        .clk_i(sys_clk), .rdata_i(rdata), .oe_i(oe), .sel_o(sel),
        .wr_o(wr), .rd_o(rd), .wdata_o(wdata)
    );

    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic rd_check(input string what, input logic [7:0] exp);
        u_host_cpu_model.get(d, ok);
        check({what, " oe"}, 40'h1, {39'h0, ok});
        check(what, {32'h0, exp}, {32'h0, d});
    endtask

    // clocks until the common lines change; a stuck scan ends the run
    task automatic wait_row(output int cyc);
        logic [15:0] last;
        last = commons;
        for (cyc = 0; cyc < 1200 && commons == last; cyc++)
        begin
            @(posedge sys_clk);
            #1;
        end
        if (commons == last)
        begin
            mismatches++;
            $display("FAIL row change expected within 1200 seen none");
            summarize();
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check("reset oe", 40'h0, {39'h0, oe});
        check("reset commons", 40'h0, {24'h0, commons});
        check("reset supply", 40'h0, {37'h0, stby, isup, bleed});
        $display("test reset done");
    endtask

    task automatic t_data;
        u_host_cpu_model.reg_wr(IDX_ADDR, 8'h0E);
        u_host_cpu_model.put(1'b0, {5'h00, IDX_DATA});
        u_host_cpu_model.put(1'b1, 8'hA1);
        u_host_cpu_model.put(1'b1, 8'hB2);
        u_host_cpu_model.put(1'b1, 8'hC3);
        u_host_cpu_model.reg_wr(IDX_ADDR, 8'h0E);
        u_host_cpu_model.put(1'b0, {5'h00, IDX_DATA});
        rd_check("y14", 8'hA1);
        rd_check("y15", 8'hB2);
        rd_check("x1 y0", 8'hC3);
        u_host_cpu_model.put(1'b0, {5'h00, IDX_DUTY});
        u_host_cpu_model.get(d, ok);
        check("write-only read", 40'h0, {39'h0, ok});
        $display("test data done");
    endtask

    task automatic t_rmw;
        u_host_cpu_model.reg_wr(IDX_DISPLAY_ON_BIT, 8'h08);
        u_host_cpu_model.reg_wr(IDX_ADDR, 8'h43);
        u_host_cpu_model.reg_wr(IDX_DATA, 8'h5A);
        u_host_cpu_model.reg_wr(IDX_ADDR, 8'h43);
        u_host_cpu_model.put(1'b0, {5'h00, IDX_DATA});
        rd_check("rmw read 1", 8'h5A);
        rd_check("rmw read 2", 8'h5A);
        u_host_cpu_model.put(1'b1, 8'h66);
        u_host_cpu_model.reg_wr(IDX_DISPLAY_ON_BIT, 8'h00);
        u_host_cpu_model.reg_wr(IDX_ADDR, 8'h43);
        u_host_cpu_model.put(1'b0, {5'h00, IDX_DATA});
        rd_check("rmw rewrite", 8'h66);
        $display("test rmw done");
    endtask

    task automatic t_wrap;
        u_host_cpu_model.reg_wr(IDX_DUTY, 8'h02);
        u_host_cpu_model.reg_wr(IDX_ADDR, 8'h07);
        u_host_cpu_model.reg_wr(IDX_DATA, 8'h11);
        u_host_cpu_model.put(1'b1, 8'h22);
        u_host_cpu_model.reg_wr(IDX_ADDR, 8'h20);
        u_host_cpu_model.put(1'b0, {5'h00, IDX_DATA});
        rd_check("duty8 wrap", 8'h22);
        u_host_cpu_model.reg_wr(IDX_DUTY, 8'h00);
        u_host_cpu_model.reg_wr(IDX_DISPLAY_ON_BIT, 8'h02);
        u_host_cpu_model.reg_wr(IDX_ADDR, 8'h83);
        u_host_cpu_model.reg_wr(IDX_DATA, 8'h33);
        u_host_cpu_model.put(1'b1, 8'h44);
        u_host_cpu_model.reg_wr(IDX_ADDR, 8'h04);
        u_host_cpu_model.put(1'b0, {5'h00, IDX_DATA});
        rd_check("x wrap", 8'h44);
        u_host_cpu_model.reg_wr(3'h5, 8'h00);
        $display("test wrap done");
    endtask

    task automatic t_panel;
        int n;
        int r;
        logic [39:0] want;
        u_host_cpu_model.reg_wr(IDX_DISPLAY_ON_BIT, 8'h02);
        u_host_cpu_model.reg_wr(IDX_ADDR, 8'h00);
        u_host_cpu_model.put(1'b0, {5'h00, IDX_DATA});
        // x priority walks memory in address order: byte n sits at 5*y+x
        for (n = 0; n < 80; n++)
            u_host_cpu_model.put(1'b1, 8'(n));
        u_host_cpu_model.reg_wr(IDX_DISPLAY_ON_BIT, 8'h70);
        for (n = 0; n < 600 && commons == 16'h0000; n++)
        begin
            @(posedge sys_clk);
            #1;
        end
        if (n == 600)
        begin
            mismatches++;
            $display("FAIL commons expected active seen idle");
            summarize();
        end
        check("one-hot", 40'h1, {39'h0, $onehot(commons)});
        r = 0;
        for (n = 0; n < 16; n++)
            if (commons[n])
                r = n;
        for (n = 0; n < 5; n++)
            want[8*n +: 8] = 8'(5 * r + n);
        check("segments", want, segs);
        wait_row(n);
        check("row time code 0", 40'({RATIO_BASE, 5'h00}), 40'(n));
        u_host_cpu_model.reg_wr(IDX_FRAME, 8'h01);
        wait_row(n);
        wait_row(n);
        check("row time code 1", 40'({RATIO_BASE, 6'h00}), 40'(n));
        check("supplies", 40'h3, {38'h0, isup, bleed});
        u_host_cpu_model.reg_wr(IDX_DUTY, 8'h20);
        repeat (4) @(posedge sys_clk);
        #1;
        check("standby", 40'h4, {37'h0, stby, isup, bleed});
        check("off commons", 40'h0, {24'h0, commons});
        $display("test panel done");
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_data();
        t_rmw();
        t_wrap();
        t_panel();
        summarize();
    end
endmodule // tb_top
